// ---- src/tdm_port_defines.svh ----
// constants for the time-division serial port of the dual voice codec
// assumes a 10 MHz system clock; included by the design file
`ifndef TDM_PORT_DEFINES_SVH
`define TDM_PORT_DEFINES_SVH

`define SYS_PERIOD_NS 100
`define BCLK_HALF_8K_NS 200
`define BCLK_HALF_16K_NS 100
`define BCLK_HALF_8K_CYC ((`BCLK_HALF_8K_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define BCLK_HALF_16K_CYC ((`BCLK_HALF_16K_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define BITS_PER_FRAME 256
`define LAST_BIT 8'hFF
`define SLOT_LAST_BIT 4'hF
`define COMP_LAST_BIT 4'h7
`define CTRL_SLOT_A 4'h0
`define CTRL_SLOT_B 4'h1
`define FIRST_DATA_SLOT 4'h2
`define I2C_ADDR_FIXED 5'h1C
`define ATTEN_MAX 3'h6
`define FIFO_DEPTH 16
`define WORD_BITS 16

`endif

// ---- src/tdm_port_pkg.sv ----
// types shared by the serial port and its testbench
// constants live in the defines header
package tdm_port_pkg;

    // what a bit position of the frame belongs to
    typedef enum logic [1:0] {
        SK_IDLE = 2'b00,
        SK_CTRL = 2'b01,
        SK_CH1 = 2'b10,
        SK_CH2 = 2'b11
    } slot_kind_e;

    // one sample with its codec channel (0 = codec 1)
    typedef struct packed {
        logic chan;
        logic [15:0] data;
    } sample_s;

endpackage

// ---- src/tdm_serial_port.sv ----
// time-division serial port of a dual voice codec, with its adc sample buffer
// assumes pins arrive asynchronously; the board resolves the three-state wires
//
// What this block does
// - bus address is 11100 plus both straps
// - straps choose this device's two slots
// - master bit clock is 256 per frame
// - receive sampled on falling edge, own slots
// - transmit launched on rising edge, own slots
// - transmit line released outside own slots
// - codec one first slot, codec two second
// - marker high at rise starts slot zero
// - only master drives the frame marker
// - receive carries dac/control, transmit carries adc
// - words 16-bit linear or 8-bit companded
// - four devices share bus, eight channels
// - adc attenuation 0 to -36 dB digital, linear words only
// - 8 or 16 kHz frame rate; the code gives 1024 or 512 system cycles per frame, about 9.8 or 19.5 kHz
// - control select high ignores slots 0,1
// - role pin high means master
// - reset low restores defaults
// - all clocks derived from system clock
`timescale 1ns/10ps
`include "tdm_port_defines.svh"

// sample buffer: width and depth shape the storage
module tdm_sample_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic [AW:0] wr_q; // write pointer, extra wrap bit
    logic [AW:0] rd_q; // read pointer, extra wrap bit
    logic push;
    logic pop;

    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module tdm_serial_port
    import tdm_port_pkg::*;
(
    // system
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // straps and mode pins
    input wire logic SLOT_ADDR_STRAP_HI,
    input wire logic SLOT_ADDR_STRAP_LO,
    input wire logic ROLE_MASTER,
    input wire logic CTRL_SEL_I2C,
    input wire logic COMPAND_8BIT,
    input wire logic RATE_16K,
    // adc attenuation, 6 dB per step, 0..6
    input wire logic [2:0] ATTEN_CH1,
    input wire logic [2:0] ATTEN_CH2,
    // serial link pins
    input wire logic BCLK_I,
    output logic BCLK_O,
    output logic BCLK_OE_N,
    input wire logic FRAME_MARKER_I,
    output logic FRAME_MARKER_O,
    output logic FRAME_MARKER_OE_N,
    input wire logic DIN,
    output logic DOUT_O,
    output logic DOUT_OE_N,
    // adc samples in
    input wire logic ADC_VALID,
    output logic ADC_READY,
    input wire sample_s ADC_SAMPLE,
    // dac samples out
    output logic DAC_STB,
    output sample_s DAC_SAMPLE,
    // control words from slots 0 and 1
    output logic CTRL_STB,
    output sample_s CTRL_WORD,
    // bus address for the control interface
    output logic [6:0] I2C_ADDR
);
    localparam int NPIN = 9;
    logic [NPIN-1:0] pin_raw; // asynchronous pins
    logic [NPIN-1:0] sync1_q; // first stage, read only by second
    logic [NPIN-1:0] sync2_q; // safe copies
    logic bclk_prev_q; // previous bit clock: own clock as master, synced pin as slave
    logic strap_done_q; // straps captured once
    logic [1:0] strap_q; // captured slot address
    logic [1:0] strap_wait_q; // edges until the synced straps settle
    logic [2:0] div_q; // master half-period counter
    logic [2:0] half_cyc; // selected half period
    logic bclk_q; // master bit clock
    logic rise_p; // bit clock rising, one cycle
    logic fall_p; // bit clock falling, one cycle
    logic fm_s; // frame marker as seen
    logic fm_q; // master frame marker
    logic master; // role
    logic framed_q; // a frame has started
    logic [7:0] bit_q; // bit position in frame
    logic [7:0] bit_nxt;
    slot_kind_e kind_now;
    slot_kind_e kind_nxt;
    logic [15:0] tx_sh_q; // transmit shift
    logic [15:0] rx_sh_q; // receive shift
    logic [15:0] hold_q [2]; // adc holding word per channel
    logic [1:0] hold_v_q; // holding word valid
    sample_s fifo_out;
    logic fifo_valid;
    logic fifo_pop;
    logic [3:0] word_last; // last bit index of a word

    assign pin_raw = {BCLK_I, FRAME_MARKER_I, DIN, SLOT_ADDR_STRAP_HI, SLOT_ADDR_STRAP_LO,
                      ROLE_MASTER, CTRL_SEL_I2C, COMPAND_8BIT, RATE_16K};

    // two-flop synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign master = sync2_q[3];
    assign word_last = sync2_q[1] ? `COMP_LAST_BIT : `SLOT_LAST_BIT;

    // slot classification from bit position; slots 0,1 only when serial control
    function automatic slot_kind_e kind_of(input logic [7:0] pos, input logic [1:0] st, input logic i2c);
        logic [3:0] slot;
        logic [3:0] base;
        slot = pos[7:4];
        base = `FIRST_DATA_SLOT + {1'b0, st, 1'b0};
        if (slot == base) begin
            kind_of = SK_CH1;
        end else if (slot == base + 4'h1) begin
            kind_of = SK_CH2;
        end else if (!i2c && (slot == `CTRL_SLOT_A || slot == `CTRL_SLOT_B)) begin
            kind_of = SK_CTRL;
        end else begin
            kind_of = SK_IDLE;
        end
    endfunction

    // straps sampled once, after the synchroniser has filled; a moving strap would move slots
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            strap_done_q <= 1'b0;
            strap_wait_q <= 2'h0;
            strap_q <= 2'h0;
        end else if (!strap_done_q) begin
            if (strap_wait_q == 2'h2) begin
                strap_done_q <= 1'b1;
                strap_q <= sync2_q[5:4];
            end else begin
                strap_wait_q <= strap_wait_q + 2'h1;
            end
        end
    end

    // bus address output
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            I2C_ADDR <= 7'h00;
        end else begin
            I2C_ADDR <= {`I2C_ADDR_FIXED, strap_q};
        end
    end

    // master bit clock divider from the system clock
    assign half_cyc = sync2_q[0] ? 3'(`BCLK_HALF_16K_CYC) : 3'(`BCLK_HALF_8K_CYC);
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= 3'h0;
            bclk_q <= 1'b0;
        end else if (!master || div_q + 3'h1 >= half_cyc) begin
            div_q <= 3'h0;
            bclk_q <= master ? !bclk_q : 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // edge pulses: own clock as master, synced pin as slave
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            bclk_prev_q <= 1'b0;
        end else begin
            bclk_prev_q <= master ? bclk_q : sync2_q[8];
        end
    end
    assign rise_p = master ? (bclk_q && !bclk_prev_q) : (sync2_q[8] && !bclk_prev_q);
    assign fall_p = master ? (!bclk_q && bclk_prev_q) : (!sync2_q[8] && bclk_prev_q);
    assign fm_s = master ? fm_q : sync2_q[7];

    // bit counter; marker high at a rise restarts the frame
    assign bit_nxt = fm_s ? 8'h00 : bit_q + 8'h01;
    assign kind_now = kind_of(bit_q, strap_q, sync2_q[2]);
    assign kind_nxt = kind_of(bit_nxt, strap_q, sync2_q[2]);
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            bit_q <= `LAST_BIT;
            framed_q <= 1'b0;
        end else if (rise_p) begin
            bit_q <= bit_nxt;
            if (fm_s) begin
                framed_q <= 1'b1;
            end
        end
    end

    // master marker: raised on the fall in bit 255, dropped on the fall in bit 0
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fm_q <= 1'b0;
        end else if (!master) begin
            fm_q <= 1'b0;
        end else if (fall_p) begin
            fm_q <= (bit_q == `LAST_BIT);
        end
    end

    // marker and bit clock pins; slaves never drive them
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            FRAME_MARKER_O <= 1'b0;
            FRAME_MARKER_OE_N <= 1'b1;
            BCLK_O <= 1'b0;
            BCLK_OE_N <= 1'b1;
        end else begin
            FRAME_MARKER_O <= fm_q;
            FRAME_MARKER_OE_N <= !master;
            BCLK_O <= bclk_q;
            BCLK_OE_N <= !master;
        end
    end

    // adc buffer; back-pressure reaches the sample source through ADC_READY
    tdm_sample_fifo #(.WIDTH(17), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .in_valid(ADC_VALID),
        .in_ready(ADC_READY),
        .in_data(ADC_SAMPLE),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );
    // buffer stalls while the channel's holding word is still unsent
    assign fifo_pop = fifo_valid && !hold_v_q[fifo_out.chan];

    // holding words; attenuation is a shift after conversion, so clipping stays
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            hold_q[0] <= 16'h0000;
            hold_q[1] <= 16'h0000;
            hold_v_q <= 2'h0;
        end else begin
            if (rise_p && bit_nxt[3:0] == 4'h0 && kind_nxt == SK_CH1) begin
                hold_v_q[0] <= 1'b0;
            end
            if (rise_p && bit_nxt[3:0] == 4'h0 && kind_nxt == SK_CH2) begin
                hold_v_q[1] <= 1'b0;
            end
            if (fifo_pop) begin
                hold_v_q[fifo_out.chan] <= 1'b1;
                if (sync2_q[1]) begin
                    hold_q[fifo_out.chan] <= fifo_out.data; // companded bytes pass untouched
                end else begin
                    hold_q[fifo_out.chan] <= $signed(fifo_out.data) >>> (fifo_out.chan ?
                        ((ATTEN_CH2 > `ATTEN_MAX) ? `ATTEN_MAX : ATTEN_CH2) :
                        ((ATTEN_CH1 > `ATTEN_MAX) ? `ATTEN_MAX : ATTEN_CH1));
                end
            end
        end
    end

    // transmit: launch on rise in own data slots, release elsewhere
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tx_sh_q <= 16'h0000;
            DOUT_O <= 1'b0;
            DOUT_OE_N <= 1'b1;
        end else if (rise_p) begin
            if ((framed_q || fm_s) && (kind_nxt == SK_CH1 || kind_nxt == SK_CH2)) begin
                DOUT_OE_N <= 1'b0;
                if (bit_nxt[3:0] == 4'h0) begin
                    // empty holding word sends silence
                    logic [15:0] w;
                    w = hold_v_q[kind_nxt == SK_CH2] ? hold_q[kind_nxt == SK_CH2] : 16'h0000;
                    if (sync2_q[1]) begin
                        w = {w[7:0], 8'h00};
                    end
                    DOUT_O <= w[15];
                    tx_sh_q <= {w[14:0], 1'b0};
                end else begin
                    DOUT_O <= tx_sh_q[15];
                    tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                end
            end else begin
                DOUT_O <= 1'b0;
                DOUT_OE_N <= 1'b1;
            end
        end
    end

    // receive: sample on fall in own slots, deliver at last bit of word
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rx_sh_q <= 16'h0000;
            DAC_STB <= 1'b0;
            DAC_SAMPLE <= '0;
            CTRL_STB <= 1'b0;
            CTRL_WORD <= '0;
        end else begin
            DAC_STB <= 1'b0;
            CTRL_STB <= 1'b0;
            if (fall_p && framed_q && kind_now != SK_IDLE && bit_q[3:0] <= word_last) begin
                rx_sh_q <= {rx_sh_q[14:0], sync2_q[6]};
                if (bit_q[3:0] == word_last) begin
                    if (kind_now == SK_CTRL) begin
                        CTRL_STB <= 1'b1;
                        CTRL_WORD <= '{chan: bit_q[4], data: {rx_sh_q[14:0], sync2_q[6]}};
                    end else begin
                        DAC_STB <= 1'b1;
                        DAC_SAMPLE <= '{chan: (kind_now == SK_CH2),
                            data: sync2_q[1] ? {8'h00, rx_sh_q[6:0], sync2_q[6]} : {rx_sh_q[14:0], sync2_q[6]}};
                    end
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    bus_addr_a: assert property (strap_done_q |=> ##1 I2C_ADDR == {5'h1C, strap_q})
        else $error("bus address wrong");
    slot_pair_a: assert property (kind_now == SK_CH1 |-> bit_q[7:4] == 4'h2 + {1'b0, strap_q, 1'b0})
        else $error("codec one slot misplaced");
    marker_bit_a: assert property (master && $rose(fm_q) |-> bit_q == 8'hFF)
        else $error("marker not at frame end");
    rx_edge_a: assert property (DAC_STB |-> $past(fall_p) && $past(kind_now) inside {SK_CH1, SK_CH2})
        else $error("sample taken outside own slot");
    tx_edge_a: assert property ($fell(DOUT_OE_N) |-> $past(rise_p))
        else $error("transmit not on rising edge");
    release_a: assert property (rise_p && !(kind_nxt inside {SK_CH1, SK_CH2}) |=> DOUT_OE_N)
        else $error("line held outside own slot");
    frame_start_a: assert property (rise_p && fm_s |=> bit_q == 8'h00 ##0 framed_q)
        else $error("frame did not restart");
    marker_drive_a: assert property (!FRAME_MARKER_OE_N |-> $past(master))
        else $error("slave drove marker");
    ctrl_ignore_a: assert property (sync2_q[2] && $stable(sync2_q[2]) |=> !CTRL_STB)
        else $error("control slot taken in bus mode");
endmodule

// ---- testbench/host_tdm_model.sv ----
// host serial port model: makes bit clock and frame marker, sends on the receive line, takes the transmit line
// assumes the device is a slave and the bench resolves the shared wires
`timescale 1ns/10ps
module host_tdm_model #(
    parameter int PHASE = 4 // system cycles per bit clock phase, 3 at least
) (
    // system
    input wire logic clk,
    // device transmit side
    input wire logic dout,
    input wire logic dout_oe_n,
    // host driven pins
    output logic bclk,
    output logic fm,
    output logic din
);
    // idle link: clock low, marker low
    initial begin
        {bclk, fm, din} = 3'b000;
    end
    // one frame; the bit clock stands still low between calls
    task automatic run_frame(input logic [15:0][15:0] tx, output logic [15:0][15:0] rx,
        output logic [15:0][15:0] drv);
        fm <= 1'b1; // marker up before the rise of bit 0
        repeat (PHASE) @(posedge clk);
        for (int b = 0; b < 256; b++) begin // sixteen 16-bit slots
            bclk <= 1'b1; // made from the system clock
            din <= tx[b / 16][15 - b % 16]; // msb first, launched at the rise
            repeat (PHASE) @(posedge clk);
            bclk <= 1'b0;
            fm <= 1'b0;
            repeat (PHASE - 1) @(posedge clk);
            @(negedge clk);
            rx[b / 16][15 - b % 16] = dout; // taken late in the bit, while the device still holds it
            drv[b / 16][15 - b % 16] = ~dout_oe_n;
            @(posedge clk);
        end
        din <= ~din; // no stale bit left on the line
    endtask
endmodule

// ---- testbench/tb_dual_codec_tdm_serial_port.sv ----
// bench for the serial port: slave frames via the host model, buffer fill and drain, master clocks
// assumes a 10 MHz system clock; the host bit is 8 system cycles long
`timescale 1ns/10ps
module tb_dual_codec_tdm_serial_port
    import tdm_port_pkg::*;
;
    localparam int LIMIT = 50000; // the run needs about 34000 cycles
    // bench driven pins
    logic clk_sys, rst_n, strap_hi, strap_lo, role, i2c, comp8, rate, adc_valid, junk_q;
    logic [2:0] a1, a2;
    sample_s adc_sample, dac_sample, ctrl_word;
    // device outputs
    logic bclk_o, bclk_oe_n, fm_o, fm_oe_n, dout_o, dout_oe_n, adc_ready, dac_stb, ctrl_stb;
    logic [6:0] i2c_addr;
    logic host_bclk, host_fm, host_din;
    wire logic bclk_w, fm_w, dout_w;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    sample_s dac_q[$], ctrl_q[$];
    // wires follow whichever party drives them; a released data line toggles
    assign bclk_w = (bclk_oe_n === 1'b0) ? bclk_o : host_bclk;
    assign fm_w = (fm_oe_n === 1'b0) ? fm_o : host_fm;
    assign dout_w = (dout_oe_n === 1'b0) ? dout_o : junk_q;
    tdm_serial_port dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .SLOT_ADDR_STRAP_HI(strap_hi), .SLOT_ADDR_STRAP_LO(strap_lo),
        .ROLE_MASTER(role), .CTRL_SEL_I2C(i2c), .COMPAND_8BIT(comp8), .RATE_16K(rate),
        .ATTEN_CH1(a1), .ATTEN_CH2(a2), .BCLK_I(bclk_w), .BCLK_O(bclk_o), .BCLK_OE_N(bclk_oe_n),
        .FRAME_MARKER_I(fm_w), .FRAME_MARKER_O(fm_o), .FRAME_MARKER_OE_N(fm_oe_n),
        .DIN(host_din), .DOUT_O(dout_o), .DOUT_OE_N(dout_oe_n),
        .ADC_VALID(adc_valid), .ADC_READY(adc_ready), .ADC_SAMPLE(adc_sample),
        .DAC_STB(dac_stb), .DAC_SAMPLE(dac_sample), .CTRL_STB(ctrl_stb), .CTRL_WORD(ctrl_word),
        .I2C_ADDR(i2c_addr)
    );
    host_tdm_model #(.PHASE(4)) host (
        .clk(clk_sys), .dout(dout_w), .dout_oe_n(dout_oe_n), .bclk(host_bclk), .fm(host_fm), .din(host_din)
    );
    // clock and time-zero values
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, strap_hi, strap_lo, role, i2c, comp8, rate, adc_valid, junk_q} = '0;
        {a1, a2, adc_sample} = '0;
    end
    // one-cycle strobes, collected where settled
    always @(negedge clk_sys) begin
        if (dac_stb === 1'b1) dac_q.push_back(dac_sample);
        if (ctrl_stb === 1'b1) ctrl_q.push_back(ctrl_word);
    end
    // toggling pattern and hang guard
    always @(posedge clk_sys) begin
        junk_q <= ~junk_q;
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            $display("unexpected run length: expected below %0d seen %0d", LIMIT, cycles);
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // expected adc word after the arithmetic shift, clamped at 6 steps
    function automatic logic [15:0] att(input logic [15:0] d, input logic [2:0] a);
        return $signed(d) >>> ((a > 3'h6) ? 3'h6 : a);
    endfunction
    // expected dac data: companded bytes land in the low byte
    function automatic logic [15:0] dexp(input logic [15:0] w);
        return comp8 ? {8'h00, w[15:8]} : w;
    endfunction
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys); // strap capture and pin sync
    endtask
    // one offer; ok tells whether it was taken
    task automatic push(input logic c, input logic [15:0] d, output logic ok);
        @(posedge clk_sys);
        adc_valid <= 1'b1;
        adc_sample <= '{chan: c, data: d};
        @(negedge clk_sys);
        ok = adc_ready;
        @(posedge clk_sys);
        adc_valid <= 1'b0;
    endtask
    // one slave frame: every slot's drive, both own words, dac and control strobes
    task automatic frame_chk(input int s, input logic [15:0] e1, input logic [15:0] e2, input logic ctl, input int f);
        logic [15:0][15:0] tx, rx, drv;
        int own;
        own = 2 + 2 * s;
        for (int k = 0; k < 16; k++) tx[k] = {k[3:0], f[3:0], 8'hC5 ^ k[7:0]};
        dac_q.delete();
        ctrl_q.delete();
        host.run_frame(tx, rx, drv);
        repeat (4) @(posedge clk_sys);
        chk("slave pin enables", 2'b11, {bclk_oe_n, fm_oe_n});
        for (int k = 0; k < 16; k++) begin
            chk("slot drive", (k == own || k == own + 1) ? 16'hFFFF : 16'h0000, drv[k]);
            if (k == own) chk("codec one word", e1, rx[k]);
            if (k == own + 1) chk("codec two word", e2, rx[k]);
        end
        chk("dac words", 2, dac_q.size());
        if (dac_q.size() == 2) begin
            chk("dac codec one", {1'b0, dexp(tx[own])}, dac_q[0]);
            chk("dac codec two", {1'b1, dexp(tx[own + 1])}, dac_q[1]);
        end
        chk("control words", ctl ? 2 : 0, ctrl_q.size());
        if (ctl && ctrl_q.size() == 2) begin
            chk("control slot 0", {1'b0, tx[0]}, ctrl_q[0]);
            chk("control slot 1", {1'b1, tx[1]}, ctrl_q[1]);
        end
    endtask
    // every strap setting, both control modes, attenuation 0..3 and clamp
    task automatic t_straps();
        logic ok1, ok2;
        for (int s = 0; s < 4; s++) begin
            {strap_hi, strap_lo} <= s[1:0];
            i2c <= s[0];
            a1 <= (s == 3) ? 3'h7 : 3'h0;
            a2 <= s[2:0];
            do_reset();
            chk("bus address", {5'b11100, s[1:0]}, i2c_addr);
            push(1'b0, 16'h9C30 + s[15:0], ok1);
            push(1'b1, 16'hC7A0 + s[15:0], ok2);
            chk("words taken", 2'b11, {ok1, ok2});
            frame_chk(s, att(16'h9C30 + s[15:0], a1), att(16'hC7A0 + s[15:0], a2), !s[0], s);
        end
    endtask
    // fill until refused with the link stopped, then drain frame by frame
    task automatic t_fill_drain();
        logic ok;
        int n;
        {a1, a2} <= 6'h00;
        i2c <= 1'b1;
        do_reset();
        n = 0;
        ok = 1'b1;
        while (ok === 1'b1 && n < 20) begin
            push(n[0], 16'h0A00 + n[15:0], ok);
            if (ok === 1'b1) n++;
        end
        @(negedge clk_sys);
        chk("words taken until full", 18, n); // 16 buffered, one holding word per channel
        chk("ready when full", 1'b0, adc_ready);
        for (int f = 0; f < 9; f++) frame_chk(3, 16'h0A00 + 16'(2 * f), 16'h0A01 + 16'(2 * f), 1'b0, f);
        chk("ready after drain", 1'b1, adc_ready);
        frame_chk(3, 16'h0000, 16'h0000, 1'b0, 9); // nothing held: zeros go out
    endtask
    // companded words: byte first in the slot, attenuation not applied
    task automatic t_compand();
        logic ok1, ok2;
        comp8 <= 1'b1;
        a1 <= 3'h2;
        do_reset();
        push(1'b0, 16'h12AB, ok1);
        push(1'b1, 16'h34CD, ok2);
        chk("words taken", 2'b11, {ok1, ok2});
        frame_chk(3, 16'hAB00, 16'hCD00, 1'b0, 5);
        comp8 <= 1'b0;
    endtask
    // master at both rates: bit clocks and system cycles between marker rises
    task automatic t_master();
        int cyc, rises, seen;
        logic pf, pb;
        role <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            rate <= r[0];
            do_reset();
            chk("master pin enables", 2'b00, {bclk_oe_n, fm_oe_n});
            {cyc, rises, seen} = '0;
            {pf, pb} = {fm_o, bclk_o};
            while (seen < 2 && cyc < 3000) begin
                @(negedge clk_sys);
                if (seen == 1) cyc++;
                if (seen == 1 && bclk_o === 1'b1 && pb === 1'b0) rises++;
                if (fm_o === 1'b1 && pf === 1'b0) seen++;
                {pf, pb} = {fm_o, bclk_o};
            end
            chk("bit clocks per frame", 256, rises);
            chk("frame cycles", r ? 512 : 1024, cyc);
        end
        role <= 1'b0;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_straps();
        t_fill_drain();
        t_compand();
        t_master();
        wrap_up();
    end
endmodule
